// *** hw/dsp_defs.svh ***
// Purpose: Named constants for the stall prevention block
// Assumes: Included by bare name, 32-bit AXI4-Lite word map
// Notes:   Percent figures are of the drive's rated current
`ifndef DSP_DEFS_SVH
`define DSP_DEFS_SVH
// ==================================================
// Register byte addresses
`define DSP_A_CTRL     8'h00
`define DSP_A_LEVEL    8'h04
`define DSP_A_ACCT     8'h08
`define DSP_A_DECT     8'h0C
`define DSP_A_FREF     8'h10
`define DSP_A_OVL      8'h14
`define DSP_A_STAT     8'h18
// ==================================================
// Field positions
`define DSP_F_ACC_SEL  1:0
`define DSP_F_DEC_SEL  3:2
`define DSP_F_RUN_SEL  5:4
`define DSP_F_RUN_EN   8
`define DSP_F_FLUX     9
`define DSP_F_B0       7:0
`define DSP_F_B1       15:8
`define DSP_F_B2       23:16
`define DSP_F_LO       15:0
`define DSP_F_HI       31:16
`define DSP_F_OV       11:0
// ==================================================
// Selections and defaults
`define DSP_SEL0       2'h0
`define DSP_SEL1       2'h1
`define DSP_SEL2       2'h2
`define DSP_SEL3       2'h3
`define DSP_ACC_LVL_D  8'h96
`define DSP_FLOOR_D    8'h32
`define DSP_RUN_LVL_D  8'hA0
`define DSP_LVL_MAX    8'hC8
`define DSP_FLOOR_MAX  8'h64
`define DSP_RUN_MIN    8'h1E
`define DSP_OV_D       12'h190
`define DSP_STEP_D     16'h0001
`define DSP_INT_FAST   16'h0040
`define DSP_INT_SLOW   16'h0004
`define DSP_MARGIN     16'h0005
`define DSP_DERATE_SH  8
// ==================================================
// Timing and bus answers
`define DSP_RUN_MS     100
`define DSP_CLK_MHZ    100
`define DSP_US_PER_MS  1000
`define DSP_OKAY       2'h0
`define DSP_SLVERR     2'h2
`endif

// *** hw/dsp_pkg.sv ***
// Purpose: Types for the stall prevention block
// Assumes: dsp_defs.svh holds the numbers
// Notes:   All module state lives in one packed struct
package dsp_pkg;
   // ==================================================
   // Ramp phase, one-hot
   typedef enum logic [4:0] {
      ST_STOP  = 5'h01,
      ST_ACCEL = 5'h02,
      ST_RUN   = 5'h04,
      ST_DECEL = 5'h08,
      ST_STALL = 5'h10
   } dsp_state_t;

   // ==================================================
   // Whole module state
   typedef struct packed {
      dsp_state_t  st;
      logic [15:0] freq;
      logic [1:0]  accel_sel;
      logic [1:0]  decel_sel;
      logic [1:0]  run_sel;
      logic        run_en;
      logic        flux_mode;
      logic [7:0]  accel_lvl;
      logic [7:0]  floor_lvl;
      logic [7:0]  run_lvl;
      logic [15:0] acc_step;
      logic [15:0] dec_step1;
      logic [15:0] dec_step2;
      logic [15:0] ref_freq;
      logic [15:0] base_freq;
      logic [11:0] ov_lvl;
      logic        flag_acc;
      logic        flag_acc_hi;
      logic        flag_run;
      logic        flag_ov;
      logic [23:0] stall_cnt;
      logic        run_stall;
      logic        acc_hold;
      logic        dec_hold;
      logic        brake;
      logic        active;
      logic        aw_have;
      logic [7:0]  aw_addr;
      logic        w_have;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
   } dsp_state_s_t;
endpackage : dsp_pkg

// *** hw/dsp_stall_prevention.sv ***
// Purpose: Stall prevention for a drive's frequency ramp, AXI4-Lite setup
// Assumes: current_pct and bus_volt are sampled values, ctrl_tick a pulse
// Notes:   Selects and the accel, floor and run levels change only while the ramp is stopped, but flux mode forces decel select 3 to 1 at any time
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dsp_defs.svh"

module dsp_stall_prevention
   import dsp_pkg::*;
#(
   parameter int unsigned RUN_STALL_CYC = `DSP_RUN_MS * `DSP_US_PER_MS * `DSP_CLK_MHZ
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] awaddr,
   input  wire logic        wvalid,
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   output logic             bvalid,
   input  wire logic        bready,
   output logic [1:0]       bresp,
   // AXI4-Lite read
   input  wire logic        arvalid,
   output logic             arready,
   input  wire logic [31:0] araddr,
   output logic             rvalid,
   input  wire logic        rready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   // Measurements
   input  wire logic        ctrl_tick,
   input  wire logic [7:0]  current_pct,
   input  wire logic [11:0] bus_volt,
   // Ramp outputs
   output logic [15:0]      freq_out,
   output logic             running,
   output logic             accel_hold,
   output logic             decel_hold,
   output logic             run_stall,
   output logic             brake_on
);

   localparam logic [23:0] STALL_CYC = 24'(RUN_STALL_CYC);

   dsp_state_s_t s_reg;
   dsp_state_s_t s_next;
   logic [15:0]  eff_lvl;
   logic [15:0]  red;
   logic [15:0]  step;
   logic [16:0]  sum;
   logic [15:0]  target;
   logic [31:0]  wd;
   logic         wr_go;
   logic         stopped;

   // ==================================================
   // Decoding shared by read and write
   function automatic logic dsp_hit(input logic [7:0] a);
      dsp_hit = (a == `DSP_A_CTRL) || (a == `DSP_A_LEVEL) || (a == `DSP_A_ACCT) ||
                (a == `DSP_A_DECT) || (a == `DSP_A_FREF) || (a == `DSP_A_OVL) ||
                (a == `DSP_A_STAT);
   endfunction : dsp_hit

   function automatic logic [31:0] dsp_rd(input dsp_state_s_t s, input logic [7:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (a)
         `DSP_A_CTRL: begin
            r[`DSP_F_ACC_SEL] = s.accel_sel;
            r[`DSP_F_DEC_SEL] = s.decel_sel;
            r[`DSP_F_RUN_SEL] = s.run_sel;
            r[`DSP_F_RUN_EN]  = s.run_en;
            r[`DSP_F_FLUX]    = s.flux_mode;
         end
         `DSP_A_LEVEL: begin
            r[`DSP_F_B0] = s.accel_lvl;
            r[`DSP_F_B1] = s.floor_lvl;
            r[`DSP_F_B2] = s.run_lvl;
         end
         `DSP_A_ACCT: r[`DSP_F_LO] = s.acc_step;
         `DSP_A_DECT: r = {s.dec_step2, s.dec_step1};
         `DSP_A_FREF: r = {s.base_freq, s.ref_freq};
         `DSP_A_OVL:  r[`DSP_F_OV] = s.ov_lvl;
         `DSP_A_STAT: r = {10'h000, s.flag_ov, s.flag_run, s.brake, s.run_stall,
                           s.dec_hold, s.acc_hold, s.freq};
         default:     r = 32'h0000_0000;
      endcase
      dsp_rd = r;
   endfunction : dsp_rd

   function automatic logic [31:0] dsp_merge(input logic [31:0] o, input logic [31:0] d,
                                             input logic [3:0] b);
      logic [31:0] m;
      m = o;
      for (int i = 0; i < 4; i++) begin
         if (b[i]) begin
            m[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      dsp_merge = m;
   endfunction : dsp_merge

   // ==================================================
   // Derated accel level above base frequency
   always_comb begin
      red = 16'h0000;
      if (s_reg.freq > s_reg.base_freq) begin
         red = (s_reg.freq - s_reg.base_freq) >> `DSP_DERATE_SH;
      end
      eff_lvl = {8'h00, s_reg.accel_lvl};
      if (s_reg.accel_lvl > s_reg.floor_lvl) begin
         if (red >= {8'h00, s_reg.accel_lvl - s_reg.floor_lvl}) begin
            eff_lvl = {8'h00, s_reg.floor_lvl};
         end else begin
            eff_lvl = {8'h00, s_reg.accel_lvl} - red;
         end
      end
   end

   // ==================================================
   // Next state: bus slave, settings, ramp
   always_comb begin
      s_next  = s_reg;
      stopped = (s_reg.st == ST_STOP);
      target  = s_reg.run_en ? s_reg.ref_freq : 16'h0000;
      step    = 16'h0000;
      sum     = 17'h0_0000;
      wd      = 32'h0000_0000;
      wr_go   = s_reg.aw_have && s_reg.w_have && !s_reg.bvalid;
      // Address and data captured in either order
      if (awvalid && s_reg.awready) begin
         s_next.aw_have = 1'b1;
         s_next.aw_addr = awaddr[7:0];
      end
      if (wvalid && s_reg.wready) begin
         s_next.w_have = 1'b1;
         s_next.w_data = wdata;
         s_next.w_strb = wstrb;
      end
      if (s_reg.bvalid && bready) begin
         s_next.bvalid = 1'b0;
      end
      // Register write once both halves are in
      if (wr_go) begin
         s_next.aw_have = 1'b0;
         s_next.w_have  = 1'b0;
         s_next.bvalid  = 1'b1;
         s_next.bresp   = dsp_hit(s_reg.aw_addr) ? `DSP_OKAY : `DSP_SLVERR;
         wd = dsp_merge(dsp_rd(s_reg, s_reg.aw_addr), s_reg.w_data, s_reg.w_strb);
         case (s_reg.aw_addr)
            `DSP_A_CTRL: begin
               s_next.run_en    = wd[`DSP_F_RUN_EN];
               s_next.flux_mode = wd[`DSP_F_FLUX];
               if (stopped) begin
                  if (wd[`DSP_F_ACC_SEL] != `DSP_SEL3) begin
                     s_next.accel_sel = wd[`DSP_F_ACC_SEL];
                  end
                  if (wd[`DSP_F_RUN_SEL] != `DSP_SEL3) begin
                     s_next.run_sel = wd[`DSP_F_RUN_SEL];
                  end
                  if (!(wd[`DSP_F_FLUX] && wd[`DSP_F_DEC_SEL] == `DSP_SEL3)) begin
                     s_next.decel_sel = wd[`DSP_F_DEC_SEL];
                  end
               end
               if (s_next.flux_mode && s_next.decel_sel == `DSP_SEL3) begin
                  s_next.decel_sel = `DSP_SEL1;
               end
            end
            `DSP_A_LEVEL: begin
               if (stopped) begin
                  s_next.accel_lvl = (wd[`DSP_F_B0] > `DSP_LVL_MAX) ? `DSP_LVL_MAX :
                                     wd[`DSP_F_B0];
                  s_next.floor_lvl = (wd[`DSP_F_B1] > `DSP_FLOOR_MAX) ? `DSP_FLOOR_MAX :
                                     wd[`DSP_F_B1];
                  s_next.run_lvl   = (wd[`DSP_F_B2] > `DSP_LVL_MAX) ? `DSP_LVL_MAX :
                                     (wd[`DSP_F_B2] < `DSP_RUN_MIN) ? `DSP_RUN_MIN :
                                     wd[`DSP_F_B2];
               end
            end
            `DSP_A_ACCT: s_next.acc_step = wd[`DSP_F_LO];
            `DSP_A_DECT: begin
               s_next.dec_step1 = wd[`DSP_F_LO];
               s_next.dec_step2 = wd[`DSP_F_HI];
            end
            `DSP_A_FREF: begin
               s_next.ref_freq  = wd[`DSP_F_LO];
               s_next.base_freq = wd[`DSP_F_HI];
            end
            `DSP_A_OVL: s_next.ov_lvl = wd[`DSP_F_OV];
            default: begin
            end
         endcase
      end
      // Read answer
      if (s_reg.rvalid && rready) begin
         s_next.rvalid = 1'b0;
      end
      if (arvalid && s_reg.arready) begin
         s_next.rvalid = 1'b1;
         s_next.rdata  = dsp_rd(s_reg, araddr[7:0]);
         s_next.rresp  = dsp_hit(araddr[7:0]) ? `DSP_OKAY : `DSP_SLVERR;
      end
      s_next.arready = !s_next.rvalid;
      s_next.awready = !s_next.aw_have && !s_next.bvalid;
      s_next.wready  = !s_next.w_have && !s_next.bvalid;

      // Run stall timer, counted in clock cycles
      if (s_reg.st == ST_RUN && s_reg.flag_run && s_reg.run_sel != `DSP_SEL0) begin
         if (s_reg.stall_cnt >= STALL_CYC) begin
            s_next.run_stall = 1'b1;
         end else begin
            s_next.stall_cnt = s_reg.stall_cnt + 24'h00_0001;
         end
      end else begin
         s_next.stall_cnt = 24'h00_0000;
      end

      // Ramp moves only on a control tick
      if (ctrl_tick) begin
         // Sample comparisons for use at the next tick
         s_next.flag_acc    = {8'h00, current_pct} > eff_lvl;
         s_next.flag_acc_hi = {8'h00, current_pct} > eff_lvl + `DSP_MARGIN;
         s_next.flag_run    = current_pct > s_reg.run_lvl;
         s_next.flag_ov     = bus_volt > s_reg.ov_lvl;
         s_next.acc_hold    = 1'b0;
         s_next.dec_hold    = 1'b0;
         s_next.brake       = 1'b0;
         case (s_reg.st)
            ST_STOP: begin
               s_next.run_stall = 1'b0;
               if (target != 16'h0000) begin
                  s_next.st = ST_ACCEL;
               end
            end
            ST_ACCEL: begin
               case (s_reg.accel_sel)
                  `DSP_SEL0: step = s_reg.acc_step;
                  `DSP_SEL1: step = s_reg.flag_acc ? 16'h0000 : s_reg.acc_step;
                  `DSP_SEL2: step = s_reg.flag_acc_hi ? 16'h0000 :
                                    (s_reg.flag_acc ? `DSP_INT_SLOW : `DSP_INT_FAST);
                  default:   step = s_reg.acc_step;
               endcase
               s_next.acc_hold = (step == 16'h0000) && (s_reg.accel_sel != `DSP_SEL0);
               sum = {1'b0, s_reg.freq} + {1'b0, step};
               if (target < s_reg.freq) begin
                  s_next.st = ST_DECEL;
               end else if (sum >= {1'b0, target}) begin
                  // A zero target settles in stop, never idles in run
                  s_next.freq = target;
                  s_next.st   = (target == 16'h0000) ? ST_STOP : ST_RUN;
               end else begin
                  s_next.freq = sum[15:0];
               end
            end
            ST_RUN: begin
               // Select 0 never raises the stall, so frequency holds
               if (s_reg.run_stall) begin
                  s_next.st = ST_STALL;
               end else if (target > s_reg.freq) begin
                  s_next.st = ST_ACCEL;
               end else if (target < s_reg.freq) begin
                  s_next.st = ST_DECEL;
               end
            end
            ST_DECEL: begin
               case (s_reg.decel_sel)
                  `DSP_SEL0: step = s_reg.dec_step1;
                  `DSP_SEL1: step = s_reg.flag_ov ? 16'h0000 : s_reg.dec_step1;
                  `DSP_SEL2: step = s_reg.flag_ov ? 16'h0000 : `DSP_INT_FAST;
                  default: begin
                     step = s_reg.flag_ov ? 16'h0000 : s_reg.dec_step1;
                     s_next.brake = 1'b1;
                  end
               endcase
               s_next.dec_hold = (step == 16'h0000) && (s_reg.decel_sel != `DSP_SEL0);
               if (target > s_reg.freq) begin
                  s_next.st = ST_ACCEL;
               end else if (s_reg.freq - target <= step) begin
                  s_next.freq = target;
                  s_next.st   = (target == 16'h0000) ? ST_STOP : ST_RUN;
               end else begin
                  s_next.freq = s_reg.freq - step;
               end
            end
            ST_STALL: begin
               step = (s_reg.run_sel == `DSP_SEL2) ? s_reg.dec_step2 :
                      s_reg.dec_step1;
               if (!s_reg.flag_run || !s_reg.run_en) begin
                  s_next.run_stall = 1'b0;
                  s_next.st        = ST_ACCEL;
               end else if (s_reg.freq <= step) begin
                  s_next.freq = 16'h0000;
               end else begin
                  s_next.freq = s_reg.freq - step;
               end
            end
            default: s_next.st = ST_STOP;
         endcase
      end
      // Running flag registered with the phase
      s_next.active = (s_next.st != ST_STOP);
   end

   // ==================================================
   // State register, synchronous reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg           <= '0;
         s_reg.st        <= ST_STOP;
         s_reg.accel_sel <= `DSP_SEL1;
         s_reg.decel_sel <= `DSP_SEL1;
         s_reg.run_sel   <= `DSP_SEL1;
         s_reg.accel_lvl <= `DSP_ACC_LVL_D;
         s_reg.floor_lvl <= `DSP_FLOOR_D;
         s_reg.run_lvl   <= `DSP_RUN_LVL_D;
         s_reg.acc_step  <= `DSP_STEP_D;
         s_reg.dec_step1 <= `DSP_STEP_D;
         s_reg.dec_step2 <= `DSP_STEP_D;
         s_reg.ov_lvl    <= `DSP_OV_D;
         s_reg.awready   <= 1'b1;
         s_reg.wready    <= 1'b1;
         s_reg.arready   <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from the state register
   assign awready    = s_reg.awready;
   assign wready     = s_reg.wready;
   assign bvalid     = s_reg.bvalid;
   assign bresp      = s_reg.bresp;
   assign arready    = s_reg.arready;
   assign rvalid     = s_reg.rvalid;
   assign rdata      = s_reg.rdata;
   assign rresp      = s_reg.rresp;
   assign freq_out   = s_reg.freq;
   assign running    = s_reg.active;
   assign accel_hold = s_reg.acc_hold;
   assign decel_hold = s_reg.dec_hold;
   assign run_stall  = s_reg.run_stall;
   assign brake_on   = s_reg.brake;

   // ==================================================
   // Checks
   sequence s_acc_over;
      ctrl_tick && s_reg.st == ST_ACCEL && s_reg.accel_sel == `DSP_SEL1 && s_reg.flag_acc;
   endsequence
   sequence s_dec_over;
      ctrl_tick && s_reg.st == ST_DECEL && s_reg.flag_ov &&
      (s_reg.decel_sel == `DSP_SEL1 || s_reg.decel_sel == `DSP_SEL3);
   endsequence

   property p_busy_locked;
      @(posedge aclk) disable iff (!aresetn)
      (s_reg.st != ST_STOP) |=> (s_reg.accel_sel == $past(s_reg.accel_sel)) &&
                                (s_reg.run_lvl == $past(s_reg.run_lvl));
   endproperty
   a_busy_locked: assert property (p_busy_locked) else $error("setting changed while driving");

   property p_no_dec3_flux;
      @(posedge aclk) disable iff (!aresetn)
      s_reg.flux_mode |-> s_reg.decel_sel != `DSP_SEL3;
   endproperty
   a_no_dec3_flux: assert property (p_no_dec3_flux) else $error("decel select 3 with flux");

   property p_levels_range;
      @(posedge aclk) disable iff (!aresetn)
      s_reg.accel_lvl <= `DSP_LVL_MAX && s_reg.floor_lvl <= `DSP_FLOOR_MAX &&
      s_reg.run_lvl >= `DSP_RUN_MIN && s_reg.run_lvl <= `DSP_LVL_MAX;
   endproperty
   a_levels_range: assert property (p_levels_range) else $error("level out of range");

   property p_acc_freeze;
      @(posedge aclk) disable iff (!aresetn)
      s_acc_over |=> s_reg.freq == $past(s_reg.freq) && s_reg.acc_hold;
   endproperty
   a_acc_freeze: assert property (p_acc_freeze) else $error("accel not frozen");

   property p_acc0_free;
      @(posedge aclk) disable iff (!aresetn)
      ctrl_tick && s_reg.st == ST_ACCEL && s_reg.accel_sel == `DSP_SEL0 |=> !s_reg.acc_hold;
   endproperty
   a_acc0_free: assert property (p_acc0_free) else $error("accel held in select 0");

   property p_dec_halt;
      @(posedge aclk) disable iff (!aresetn)
      s_dec_over |=> s_reg.freq == $past(s_reg.freq) && s_reg.dec_hold;
   endproperty
   a_dec_halt: assert property (p_dec_halt) else $error("decel not halted");

   property p_brake;
      @(posedge aclk) disable iff (!aresetn)
      ctrl_tick && s_reg.st == ST_DECEL && s_reg.decel_sel == `DSP_SEL3 |=> s_reg.brake;
   endproperty
   a_brake: assert property (p_brake) else $error("brake path idle in select 3");

   property p_floor;
      @(posedge aclk) disable iff (!aresetn)
      (s_reg.accel_lvl > s_reg.floor_lvl) |-> eff_lvl >= {8'h00, s_reg.floor_lvl};
   endproperty
   a_floor: assert property (p_floor) else $error("accel level under floor");

   property p_run0_quiet;
      @(posedge aclk) disable iff (!aresetn)
      s_reg.run_sel == `DSP_SEL0 && !s_reg.run_stall |=> !s_reg.run_stall;
   endproperty
   a_run0_quiet: assert property (p_run0_quiet) else $error("run stall in select 0");

   property p_sample;
      @(posedge aclk) disable iff (!aresetn)
      ctrl_tick |=> s_reg.flag_ov == ($past(bus_volt) > $past(s_reg.ov_lvl));
   endproperty
   a_sample: assert property (p_sample) else $error("voltage flag not sampled");

   property p_bhold;
      @(posedge aclk) disable iff (!aresetn)
      bvalid && !bready |=> bvalid && $stable(bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");

endmodule : dsp_stall_prevention
`default_nettype wire

// *** bench/dsp_motor_model.sv ***
// Purpose: Motor seen through the power stage
// Assumes: Load demand comes from the bench
// Notes:   Current follows load one clock late
`timescale 1ns/1ps
`default_nettype none
module dsp_motor_model (
   // Clock
   input  wire logic        aclk,
   // Drive side
   input  wire logic [15:0] freq,
   input  wire logic [7:0]  load,
   // Measurements
   output logic [7:0]       current_pct = 8'h00,
   output logic [11:0]      bus_volt = 12'h000
);
   // Sampled current and a bus that rises with speed
   always @(posedge aclk) begin
      current_pct <= load;
      bus_volt    <= 12'h100 + {4'h0, freq[15:8]};
   end
endmodule : dsp_motor_model
`default_nettype wire

// *** bench/tb_drive_stall_prevention.sv ***
// Purpose: Self-checking bench for the stall prevention block
// Assumes: Run stall time cut to 20 clocks
// Notes:   Control tick every fourth clock
`timescale 1ns/1ps
`default_nettype none
module tb_drive_stall_prevention;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic ctrl_tick = 0, awready, wready, bvalid, arready, rvalid, running, ahold, dhold;
   logic rstall, brake;
   logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, got;
   logic [3:0]  wstrb = 4'hF;
   logic [1:0]  bresp, rresp, rr, br, tc = 0;
   logic [7:0]  load = 0, cur, rl;
   logic [11:0] volt;
   logic [15:0] freq, step;
   int          mismatches = 0, checks = 0;
   // ==========
   // Clock, tick, design and motor
   initial forever #5 aclk = ~aclk;
   always @(posedge aclk) begin
      tc <= tc + 2'h1;
      ctrl_tick <= (tc == 2'h3);
   end
   dsp_stall_prevention #(.RUN_STALL_CYC(20)) uut (.aclk, .aresetn, .awvalid, .awready,
      .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
      .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .ctrl_tick, .current_pct(cur),
      .bus_volt(volt), .freq_out(freq), .running, .accel_hold(ahold), .decel_hold(dhold),
      .run_stall(rstall), .brake_on(brake));
   dsp_motor_model motor (.aclk, .freq, .load, .current_pct(cur), .bus_volt(volt));
   // ==========
   // Checking and bus tasks
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // Expected level word after clamping to the documented ranges
   function automatic logic [31:0] lvl_exp(input logic [7:0] a, input logic [7:0] f,
                                           input logic [7:0] r);
      logic [7:0] rc;
      rc = (r > 8'hC8) ? 8'hC8 : ((r < 8'h1E) ? 8'h1E : r);
      return {8'h00, rc, (f > 8'h64) ? 8'h64 : f, (a > 8'hC8) ? 8'hC8 : a};
   endfunction : lvl_exp
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= {24'h00_0000, a};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      br = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      araddr <= {24'h00_0000, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      rr = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask : rd
   task automatic till(input logic [15:0] f);
      for (int i = 0; i < 4000 && freq !== f; i++) @(posedge aclk);
   endtask : till
   task automatic summarize;
      if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : summarize
   // ==========
   // Hang guard
   initial begin
      repeat (30000) @(posedge aclk);
      mismatches++;
      summarize();
   end
   // ==========
   // Scenarios
   initial begin
      void'($urandom(7766));
      step = 16'h0001 + 16'($urandom % 16);
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(8'h00, got);
      chk("ctrl", got, 32'h0000_0015);
      rd(8'h04, got);
      chk("level", got, 32'h00A0_3296);
      rd(8'h1C, got);
      chk("rresp", {30'h0, rr}, 32'h0000_0002);
      wr(8'h1C, 32'h0000_0000);
      chk("bresp_bad", {30'h0, br}, 32'h0000_0002);
      wr(8'h04, 32'h00FF_FFFF);
      chk("bresp_ok", {30'h0, br}, 32'h0000_0000);
      rd(8'h04, got);
      chk("clamp", got, lvl_exp(8'hFF, 8'hFF, 8'hFF));
      rl = 8'($urandom);
      wr(8'h04, {8'h00, rl, ~rl, rl ^ 8'h5A});
      rd(8'h04, got);
      chk("lvlrnd", got, lvl_exp(rl ^ 8'h5A, ~rl, rl));
      rl = 8'($urandom % 30);
      wr(8'h04, {8'h00, rl, 16'h3296});
      rd(8'h04, got);
      chk("runmin", got, lvl_exp(8'h96, 8'h32, rl));
      wr(8'h00, 32'h0000_021D);
      rd(8'h00, got);
      chk("flux", got, 32'h0000_0215);
      // Accel select 0 ignores heavy current
      wr(8'h08, {16'h0000, step});
      wr(8'h0C, 32'h0100_0100);
      wr(8'h10, 32'hFFFF_0100);
      load <= 8'hFF;
      wr(8'h00, 32'h0000_0110);
      repeat (24) @(posedge aclk);
      chk("acc0", {15'h0, ahold, 15'h0, freq % step == 0 && freq != 0}, 32'h0000_0001);
      wr(8'h00, 32'h0000_0111);
      rd(8'h00, got);
      chk("busy", got, 32'h0000_0110);
      wr(8'h00, 32'h0000_0010);
      till(16'h0000);
      // Accel select 1 freezes, then resumes
      wr(8'h00, 32'h0000_0111);
      repeat (24) @(posedge aclk);
      chk("hold", {15'h0, ahold, freq}, 32'h0001_0000);
      load <= 8'h0A;
      till(16'h0100);
      chk("ref", {16'h0, freq}, 32'h0000_0100);
      // Run stall, then recovery
      load <= 8'hFF;
      for (int i = 0; i < 400 && rstall !== 1'b1; i++) @(posedge aclk);
      chk("rstall", {31'h0, rstall}, 32'h0000_0001);
      repeat (16) @(posedge aclk);
      chk("down", {31'h0, freq < 16'h0100}, 32'h0000_0001);
      load <= 8'h0A;
      till(16'h0100);
      chk("back", {16'h0, freq}, 32'h0000_0100);
      // Accel select 2 ignores its step, decel select 3 holds and brakes
      wr(8'h00, 32'h0000_0011);
      till(16'h0000);
      wr(8'h14, 32'h0000_00FF);
      wr(8'h00, 32'h0000_010E);
      rd(8'h00, got);
      chk("sel3", got, 32'h0000_010E);
      for (int i = 0; i < 40 && freq !== 16'h0100; i++) @(posedge aclk);
      chk("acc2", {16'h0, freq}, 32'h0000_0100);
      wr(8'h00, 32'h0000_000E);
      repeat (12) @(posedge aclk);
      chk("brake", {14'h0, brake, dhold, freq}, 32'h0003_0100);
      wr(8'h14, 32'h0000_0FFF);
      till(16'h0000);
      repeat (8) @(posedge aclk);
      chk("rest", {30'h0, running, brake}, 32'h0000_0000);
      // Flux mode pushes decel select 3 back to 1
      wr(8'h00, 32'h0000_020E);
      rd(8'h00, got);
      chk("force", got, 32'h0000_0206);
      summarize();
   end
endmodule : tb_drive_stall_prevention
`default_nettype wire
